// File: core/adcp_ctrl.sv
// Converter sequence and priority controller with register port
`timescale 1ns/1ns
module adcp_ctrl
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire adcp_pkg::adcp_bus_s bus_i,
  output logic [31:0] rdata_o,
  input wire adcp_pkg::adcp_core_s core_i,
  input wire logic prio_trig_pin_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [3:0] conv_ch_o,
  output logic normal_done_irq_o,
  output logic prio_done_irq_o,
  output logic irq_o
);
  import adcp_pkg::*;

  typedef struct packed
  {
    adcp_state_e st;
    logic scan;
    logic rep;
    logic run_rep;
    logic [1:0] itm;
    logic [3:0] ch;
    logic [3:0] pch;
    logic hw_en;
    logic nbusy;
    logic ndone;
    logic pbusy;
    logic pdone;
    logic [3:0] cur;
    logic [2:0] cnt;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [7:0][9:0] res;
    logic [7:0] rf;
    logic [7:0] ovr;
    logic [9:0] pres;
    logic prf;
    logic povr;
    logic [31:0] rdata;
    logic start;
    logic abort;
    logic [3:0] conv_ch;
    logic nirq;
    logic pirq;
    logic irq;
  } adcp_ctrl_s;

  adcp_ctrl_s q;
  adcp_ctrl_s next_q;
  logic trig_fall;
  logic p_req;
  logic n_req;
  logic soft_rst;
  logic last;
  logic [2:0] lim;
  logic [2:0] ridx;

  adcp_trig_sync u_trig
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(prio_trig_pin_i),
    .fall_o(trig_fall)
  );

  // ****************************************************
  // Request decode
  // ****************************************************
  assign p_req = (bus_i.we && bus_i.addr == OFF_PMOD
    && bus_i.wdata[PM_START]) || (q.hw_en && trig_fall);
  assign n_req = bus_i.we && bus_i.addr == OFF_NMOD
    && bus_i.wdata[NM_START];
  assign soft_rst = bus_i.we && bus_i.addr == OFF_SRST
    && bus_i.wdata[SR_GO];
  // Scan runs from channel 0 up to the selected channel
  assign last = !q.scan || q.cur == q.ch;
  assign lim = (q.itm == 2'h1) ? ITM_LIM_4 :
    (q.itm == 2'h2) ? ITM_LIM_8 : ITM_LIM_1;
  assign ridx = (q.run_rep && !q.scan) ? q.cnt : q.cur[2:0];

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    logic fin;
    logic ev;
    logic [31:0] rd;
    logic [2:0] ri;
    next_q = q;
    fin = 1'b0;
    ev = 1'b0;
    rd = 32'h0000_0000;
    ri = bus_i.addr[4:2];
    next_q.start = 1'b0;
    next_q.abort = 1'b0;
    next_q.nirq = 1'b0;
    next_q.pirq = 1'b0;
    // Reads first so that a hardware set in the same cycle wins
    if (bus_i.re)
    begin
      case (bus_i.addr)
        OFF_NMOD:
        begin
          rd[NM_SCAN] = q.scan;
          rd[NM_REP] = q.rep;
          rd[NM_ITM +: 2] = q.itm;
          rd[NM_BUSY] = q.nbusy;
          rd[NM_DONE] = q.ndone;
          next_q.ndone = 1'b0;
        end
        OFF_CHSEL: rd[3:0] = q.ch;
        OFF_PMOD:
        begin
          rd[3:0] = q.pch;
          rd[PM_HWEN] = q.hw_en;
          rd[PM_BUSY] = q.pbusy;
          rd[PM_DONE] = q.pdone;
          next_q.pdone = 1'b0;
        end
        OFF_STS: rd[1:0] = q.sts;
        OFF_MSK: rd[1:0] = q.msk;
        OFF_PRES:
        begin
          rd[9:0] = q.pres;
          rd[RS_OVR] = q.povr;
          rd[RS_RF] = q.prf;
          next_q.prf = 1'b0;
          next_q.povr = 1'b0;
        end
        default:
        begin
          if (bus_i.addr[7:5] == OFF_RES0[7:5] && bus_i.addr[1:0] == 2'h0)
          begin
            rd[9:0] = q.res[ri];
            rd[RS_OVR] = q.ovr[ri];
            rd[RS_RF] = q.rf[ri];
            next_q.rf[ri] = 1'b0;
            next_q.ovr[ri] = 1'b0;
          end
        end
      endcase
    end
    next_q.rdata = rd;
    if (bus_i.we)
    begin
      case (bus_i.addr)
        OFF_NMOD:
        begin
          next_q.scan = bus_i.wdata[NM_SCAN];
          next_q.rep = bus_i.wdata[NM_REP];
          next_q.itm = bus_i.wdata[NM_ITM +: 2];
        end
        OFF_CHSEL: next_q.ch = bus_i.wdata[3:0];
        OFF_PMOD:
        begin
          next_q.pch = bus_i.wdata[3:0];
          next_q.hw_en = bus_i.wdata[PM_HWEN];
        end
        OFF_STS: next_q.sts = q.sts & ~bus_i.wdata[1:0];
        OFF_MSK: next_q.msk = bus_i.wdata[1:0];
        default: ;
      endcase
    end
    case (q.st)
      ST_IDLE:
      begin
        if (p_req)
        begin
          next_q.pbusy = 1'b1;
          next_q.start = 1'b1;
          next_q.conv_ch = next_q.pch;
          next_q.st = ST_PCONV;
        end
        else if (n_req)
        begin
          next_q.nbusy = 1'b1;
          // Mode bits written with the start bit apply to this run
          next_q.run_rep = next_q.rep;
          next_q.cur = next_q.scan ? 4'h0 : q.ch;
          next_q.cnt = 3'h0;
          next_q.start = 1'b1;
          next_q.conv_ch = next_q.scan ? 4'h0 : q.ch;
          next_q.st = ST_NCONV;
        end
      end
      ST_NCONV:
      begin
        // A restart while running is refused; soft reset comes first
        if (core_i.done)
        begin
          if (q.rf[ridx])
          begin
            next_q.ovr[ridx] = 1'b1;
          end
          next_q.res[ridx] = core_i.data;
          next_q.rf[ridx] = 1'b1;
          if (q.run_rep)
          begin
            fin = !q.rep;
            if (q.scan)
            begin
              ev = last;
            end
            else
            begin
              ev = q.cnt == lim;
              next_q.cnt = ev ? 3'h0 : 3'(q.cnt + 3'h1);
            end
          end
          else
          begin
            fin = last;
            ev = last;
          end
          if (ev)
          begin
            next_q.ndone = 1'b1;
            next_q.nirq = 1'b1;
            next_q.sts[IRQ_NORM] = 1'b1;
          end
          if (fin)
          begin
            next_q.nbusy = 1'b0;
          end
          next_q.cur = (q.scan && !last) ? 4'(q.cur + 4'h1) :
            (q.scan ? 4'h0 : q.ch);
        end
        if (p_req)
        begin
          next_q.abort = !core_i.done;
          next_q.pbusy = 1'b1;
          next_q.start = 1'b1;
          next_q.conv_ch = next_q.pch;
          next_q.st = ST_PCONV;
        end
        else if (core_i.done)
        begin
          next_q.start = !fin;
          next_q.conv_ch = next_q.cur;
          next_q.st = fin ? ST_IDLE : ST_NCONV;
        end
      end
      ST_PCONV:
      begin
        // Priority requests here are dropped; normal flags are left alone
        if (core_i.done)
        begin
          next_q.povr = q.prf;
          next_q.pres = core_i.data;
          next_q.prf = 1'b1;
          next_q.pdone = 1'b1;
          next_q.pbusy = 1'b0;
          next_q.pirq = 1'b1;
          next_q.sts[IRQ_PRIO] = 1'b1;
          next_q.start = q.nbusy;
          next_q.conv_ch = q.cur;
          next_q.st = q.nbusy ? ST_NCONV : ST_IDLE;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
    if (soft_rst)
    begin
      next_q.abort = q.st != ST_IDLE;
      next_q.start = 1'b0;
      next_q.nbusy = 1'b0;
      next_q.pbusy = 1'b0;
      next_q.cnt = 3'h0;
      next_q.st = ST_IDLE;
    end
    next_q.irq = |(next_q.sts & next_q.msk);
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.itm <= RST_ITM;
      q.ch <= RST_CH;
      q.pch <= RST_CH;
      q.msk <= RST_MSK;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign conv_start_o = q.start;
  assign conv_abort_o = q.abort;
  assign conv_ch_o = q.conv_ch;
  assign normal_done_irq_o = q.nirq;
  assign prio_done_irq_o = q.pirq;
  assign irq_o = q.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_norm_done;
    q.st == ST_NCONV && core_i.done && !soft_rst;
  endsequence
  sequence s_prio_done;
    q.st == ST_PCONV && core_i.done && !soft_rst;
  endsequence

  prio_preempt_a: assert property (
    q.st == ST_NCONV && p_req && !core_i.done && !soft_rst
    |=> q.st == ST_PCONV && q.abort && q.start && q.conv_ch == q.pch)
    else $error("priority start did not pre-empt");
  prio_result_a: assert property (
    s_prio_done |=> q.prf && q.pres == $past(core_i.data))
    else $error("priority result not stored");
  hw_trigger_a: assert property (
    q.st == ST_NCONV && q.hw_en && trig_fall && !soft_rst
    |=> q.st == ST_PCONV && q.pbusy)
    else $error("hardware trigger did not pre-empt");
  resume_chan_a: assert property (
    s_prio_done ##0 q.nbusy |=> q.start && q.conv_ch == $past(q.cur)
    && q.st == ST_NCONV)
    else $error("sequence did not resume on suspended channel");
  repeat_stop_a: assert property (
    s_norm_done ##0 q.run_rep && !q.rep |=> !q.nbusy ##1 !q.start)
    else $error("repeat did not stop");
  fixed_single_a: assert property (
    s_norm_done ##0 !q.run_rep && !q.scan
    |=> q.ndone && !q.nbusy && q.nirq)
    else $error("fixed single completion wrong");
  scan_single_a: assert property (
    s_norm_done ##0 !q.run_rep && q.scan && q.cur != q.ch
    |=> q.nbusy && !q.nirq)
    else $error("scan single finished early");
  repeat_four_a: assert property (
    s_norm_done ##0 q.run_rep && q.rep && !q.scan && q.itm == 2'h1
    && q.cnt != 3'h3 |=> q.nbusy && !q.nirq)
    else $error("repeat interrupt too early");
  repeat_store_a: assert property (
    s_norm_done ##0 q.run_rep && !q.scan |=> q.rf[$past(q.cnt)])
    else $error("repeat result register wrong");
  scan_pass_a: assert property (
    s_norm_done ##0 q.run_rep && q.rep && q.scan && q.cur == q.ch
    |=> q.nirq && q.ndone && q.nbusy)
    else $error("scan pass not flagged");
  prio_flags_a: assert property (
    s_prio_done |=> q.pirq && q.pdone && !q.pbusy)
    else $error("priority completion flags wrong");
  done_clear_a: assert property (
    bus_i.re && bus_i.addr == OFF_NMOD && !core_i.done |=> !q.ndone)
    else $error("done not cleared on read");
  busy_set_a: assert property (
    q.st == ST_IDLE && n_req && !p_req && !soft_rst |=> q.nbusy)
    else $error("normal busy not set");
  keep_norm_a: assert property (
    q.st == ST_PCONV && !soft_rst && !(bus_i.re && bus_i.addr == OFF_NMOD)
    |=> $stable(q.nbusy) && $stable(q.ndone))
    else $error("normal flags changed during priority");
  prio_ignore_a: assert property (
    q.st == ST_PCONV && p_req && !core_i.done |=> !q.start)
    else $error("nested priority start not ignored");
  irq_pulse_a: assert property (
    q.nirq |=> !q.nirq)
    else $error("interrupt pulse longer than one cycle");

endmodule

// File: core/adcp_pkg.sv
// Constants, types and register map of the converter sequence controller
//
// Behaviour
// - Software priority start during a normal conversion suspends it and starts priority.
// - Priority run is one fixed-channel conversion into the priority result register.
// - Permitted hardware priority trigger pre-empts a normal conversion the same way.
// - After pre-emption the sequence resumes on the suspended channel.
// - Clearing repeat finishes the current conversion, leaves repeat, clears busy.
// - Fixed single completion sets done, clears busy, pulses normal interrupt.
// - Scan single sets done, clears busy, interrupts only after last channel.
// - Fixed repeat keeps busy; done and interrupt every 1, 4 or 8 conversions.
// - Fixed repeat stores to result 0, rotates 0 to 3, or 0 to 7.
// - Scan repeat sets done and interrupts each pass while busy stays 1.
// - Priority completion pulses priority interrupt, sets priority done, clears busy.
// - Normal and priority done flags clear when software reads them.
// - Normal start from idle sets normal busy unless a priority start comes with it; priority start sets priority busy.
// - Priority conversion keeps normal busy and done values unchanged.
// - Priority start while a priority conversion runs is ignored.
package adcp_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] OFF_NMOD = 8'h00;
  localparam logic [7:0] OFF_CHSEL = 8'h04;
  localparam logic [7:0] OFF_PMOD = 8'h08;
  localparam logic [7:0] OFF_SRST = 8'h0C;
  localparam logic [7:0] OFF_STS = 8'h10;
  localparam logic [7:0] OFF_MSK = 8'h14;
  localparam logic [7:0] OFF_RES0 = 8'h20;
  localparam logic [7:0] OFF_PRES = 8'h40;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int NM_START = 0;
  localparam int NM_SCAN = 1;
  localparam int NM_REP = 2;
  localparam int NM_ITM = 4;
  localparam int NM_BUSY = 6;
  localparam int NM_DONE = 7;
  localparam int PM_START = 4;
  localparam int PM_HWEN = 5;
  localparam int PM_BUSY = 6;
  localparam int PM_DONE = 7;
  localparam int SR_GO = 0;
  localparam int RS_OVR = 30;
  localparam int RS_RF = 31;
  localparam int IRQ_NORM = 0;
  localparam int IRQ_PRIO = 1;

  // ****************************************************
  // Counts and reset values
  // ****************************************************
  localparam logic [2:0] ITM_LIM_1 = 3'h0;
  localparam logic [2:0] ITM_LIM_4 = 3'h3;
  localparam logic [2:0] ITM_LIM_8 = 3'h7;
  localparam logic [3:0] RST_CH = 4'h0;
  localparam logic [1:0] RST_ITM = 2'h0;
  localparam logic [1:0] RST_MSK = 2'h0;
  localparam logic RST_TRIG_LVL = 1'b1;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_NCONV = 2'b01,
    ST_PCONV = 2'b11
  } adcp_state_e;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } adcp_bus_s;

  typedef struct packed
  {
    logic done;
    logic [9:0] data;
  } adcp_core_s;

endpackage

// File: core/adcp_trig_sync.sv
// Pin synchroniser with falling-edge pulse for the hardware trigger
`timescale 1ns/1ns
module adcp_trig_sync
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic fall_o
);
  import adcp_pkg::*;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic fall;
  } adcp_sync_s;

  adcp_sync_s q;
  adcp_sync_s next_q;

  // ****************************************************
  // Sync chain
  // ****************************************************
  // A change counts only once the second and third stages agree
  always_comb
  begin
    next_q = q;
    next_q.s1 = pin_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.fall = 1'b0;
    if (q.s2 == q.s3)
    begin
      next_q.lvl = q.s3;
      next_q.fall = q.lvl & ~q.s3;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= {RST_TRIG_LVL, RST_TRIG_LVL, RST_TRIG_LVL, RST_TRIG_LVL, 1'b0};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign fall_o = q.fall;

endmodule

// File: verif/adcp_core_model.sv
// Behavioural model of the analog conversion core
`timescale 1ns/1ns
module adcp_core_model
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] lat_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [3:0] ch_i,
  output adcp_pkg::adcp_core_s core_o
);
  import adcp_pkg::*;
  logic busy;
  logic done;
  logic tog;
  logic [7:0] cnt;
  logic [3:0] ch;
  // Data wiggles outside done, so a stale sample never looks valid
  assign core_o.done = done;
  assign core_o.data = done ? {6'h2A, ch} : {5{tog, ~tog}};
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      tog <= 1'b0;
      cnt <= 8'h00;
      ch <= 4'h0;
    end
    else
    begin
      tog <= ~tog;
      done <= 1'b0;
      if (start_i)
      begin
        busy <= 1'b1;
        cnt <= lat_i;
        ch <= ch_i;
      end
      else if (abort_i)
        busy <= 1'b0;
      else if (busy && cnt <= 8'h01)
      begin
        done <= 1'b1;
        busy <= 1'b0;
      end
      else if (busy)
        cnt <= cnt - 8'h01;
    end
  end
endmodule

// File: verif/testbench.sv
// Self-checking testbench of the converter sequence controller
`timescale 1ns/1ns
module testbench;
  import adcp_pkg::*;
  logic clk_i, rst_b_i, pin, c_start, c_abort, nirq, pirq, irq;
  logic nirq_q, pirq_q;
  logic [3:0] c_ch;
  logic [7:0] lat;
  logic [31:0] rdata, v;
  adcp_bus_s bus;
  adcp_core_s core;
  int mismatches, n_checks, n_start, n_abort, n_nirq, n_pirq, k, j, per;
  logic [3:0] chq[$];
  adcp_ctrl u_dut(.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus),
    .rdata_o(rdata), .core_i(core), .prio_trig_pin_i(pin),
    .conv_start_o(c_start), .conv_abort_o(c_abort), .conv_ch_o(c_ch),
    .normal_done_irq_o(nirq), .prio_done_irq_o(pirq), .irq_o(irq));
  adcp_core_model u_core(.clk_i(clk_i), .rst_b_i(rst_b_i), .lat_i(lat),
    .start_i(c_start), .abort_i(c_abort), .ch_i(c_ch), .core_o(core));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ************************************************
  // Tasks
  // ************************************************
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  task timeout;
    mismatches++;
    $display("unexpected wait: expected event seen none");
    final_report();
  endtask
  // Strobes drop for one cycle after each access, so no gap-free pairs
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus.we <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1 d = rdata;
    @(posedge clk_i);
  endtask
  task look;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task clr;
    n_start = 0;
    n_abort = 0;
    n_nirq = 0;
    n_pirq = 0;
    chq.delete();
  endtask
  task wait_cnt(input int which, input int target);
    int i, c;
    for (i = 0; i < 4000; i++)
    begin
      c = which == 0 ? n_start : which == 1 ? n_nirq : which == 2 ? n_pirq
        : n_abort;
      if (c >= target)
        break;
      @(posedge clk_i);
    end
    if (i == 4000)
      timeout();
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 500; i++)
    begin
      rd(OFF_NMOD, v);
      if (v[NM_BUSY] === 1'b0)
        break;
    end
    if (i == 500)
      timeout();
  endtask
  task chk_chans(input logic [31:0] e, input int n);
    chk("chan count", n, chq.size());
    for (int i = 0; i < n && i < chq.size(); i++)
      chk("chan", e[4*(n-1-i) +: 4], {28'h0, chq[i]});
  endtask
  // Pulses are sampled mid-cycle, away from the launching edge
  always @(negedge clk_i)
  begin
    if (c_start === 1'b1)
      chq.push_back(c_ch);
    n_start += (c_start === 1'b1);
    n_abort += (c_abort === 1'b1);
    n_nirq += (nirq === 1'b1);
    n_pirq += (pirq === 1'b1);
    if (nirq_q && nirq === 1'b1) chk("nirq width", 0, 1);
    if (pirq_q && pirq === 1'b1) chk("pirq width", 0, 1);
    nirq_q = (nirq === 1'b1);
    pirq_q = (pirq === 1'b1);
  end
  // ************************************************
  // Scenarios
  // ************************************************
  initial
  begin
    rst_b_i = 1'b0;
    bus = '0;
    pin = 1'b1;
    lat = 8'h1E;
    mismatches = 0;
    n_checks = 0;
    clr();
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (k = 0; k < 5; k++)
    begin
      rd(8'({40'h00_0810_1418} >> (8 * k)), v);
      chk("reset value", 32'h0000_0000, v);
    end
    // Fixed single, masked then unmasked interrupt
    wr(OFF_MSK, 32'h0000_0002);
    wr(OFF_CHSEL, 32'h0000_0005);
    wr(OFF_NMOD, 32'h0000_0001);
    rd(OFF_NMOD, v); chk("nmod busy", 32'h0000_0040, v);
    wait_cnt(1, 1);
    rd(OFF_NMOD, v); chk("nmod done", 32'h0000_0080, v);
    rd(OFF_NMOD, v); chk("nmod reread", 32'h0000_0000, v);
    look();
    chk("irq masked", 0, irq);
    rd(OFF_STS, v); chk("sts", 32'h0000_0001, v);
    wr(OFF_MSK, 32'h0000_0001); look(); chk("irq", 1, irq);
    wr(OFF_STS, 32'h0000_0001); look(); chk("irq clr", 0, irq);
    rd(8'h34, v); chk("res5", 32'h8000_02A5, v);
    chk_chans(32'h5, 1);
    // Scan single with a prompt core
    lat <= 8'h02;
    clr();
    wr(OFF_CHSEL, 32'h0000_0003);
    wr(OFF_NMOD, 32'h0000_0003);
    wait_cnt(1, 1); look();
    chk("scan irqs", 1, n_nirq);
    chk_chans(32'h0123, 4);
    rd(OFF_NMOD, v); chk("scan done", 32'h0000_0082, v);
    for (k = 0; k < 4; k++)
    begin
      rd(OFF_RES0 + 8'(4 * k), v);
      chk("scan res", 32'h8000_02A0 + k, v);
    end
    // Fixed repeat for every interrupt spacing, then stop
    lat <= 8'h1E;
    wr(OFF_CHSEL, 32'h0000_0002);
    for (k = 0; k < 3; k++)
    begin
      per = k == 0 ? 1 : k == 1 ? 4 : 8;
      clr();
      wr(OFF_NMOD, 32'h0000_0005 | (k << NM_ITM));
      wait_cnt(1, 1);
      chk("rep starts", per + 1, n_start);
      rd(OFF_NMOD, v); chk("rep flags", 32'h0000_00C4 | (k << 4), v);
      for (j = 0; j < per; j++)
      begin
        rd(OFF_RES0 + 8'(4 * j), v);
        chk("rep res", 32'h8000_02A2, v);
      end
      wr(OFF_NMOD, k << NM_ITM);
      wait_idle(); look();
      chk("stop starts", per + 1, n_start);
      rd(OFF_RES0, v);
      rd(OFF_NMOD, v);
    end
    // Software pre-emption of a scan, then a refused second request
    wr(OFF_PMOD, 32'h0000_000B);
    wr(OFF_CHSEL, 32'h0000_0003);
    clr();
    wr(OFF_NMOD, 32'h0000_0003);
    wait_cnt(0, 3);
    wr(OFF_PMOD, 32'h0000_001B);
    wr(OFF_PMOD, 32'h0000_001B);
    rd(OFF_NMOD, v); chk("nmod kept", 32'h0000_0042, v);
    rd(OFF_PMOD, v); chk("pmod busy", 32'h0000_004B, v & 32'hEF);
    wait_cnt(2, 1);
    rd(OFF_PMOD, v); chk("pmod done", 32'h0000_008B, v & 32'hEF);
    rd(OFF_PMOD, v); chk("pmod reread", 32'h0000_000B, v & 32'hEF);
    rd(OFF_PRES, v); chk("prio res", 32'h8000_02AB, v);
    wait_cnt(1, 1);
    chk("aborts", 1, n_abort);
    chk_chans(32'h012B23, 6);
    // Hardware trigger pre-empts a fixed single
    wr(OFF_PMOD, 32'h0000_0027);
    wr(OFF_CHSEL, 32'h0000_0005);
    clr();
    wr(OFF_NMOD, 32'h0000_0001);
    wait_cnt(0, 1);
    pin <= 1'b0;
    wait_cnt(3, 1);
    wait_cnt(2, 1);
    wait_cnt(1, 1);
    pin <= 1'b1;
    chk_chans(32'h575, 3);
    // Restart through the soft reset only
    clr();
    wr(OFF_NMOD, 32'h0000_0001);
    wait_cnt(0, 1);
    wr(OFF_SRST, 32'h0000_0001); look();
    chk("srst abort", 1, n_abort);
    rd(OFF_NMOD, v); chk("srst busy", 0, v[NM_BUSY]);
    wr(OFF_NMOD, 32'h0000_0001);
    wait_cnt(1, 1);
    chk("restart", 2, n_start);
    // Scan repeat flags every pass with busy held, then stops
    lat <= 8'h02;
    clr();
    wr(OFF_CHSEL, 32'h0000_0001);
    wr(OFF_NMOD, 32'h0000_0007);
    wait_cnt(1, 2);
    rd(OFF_NMOD, v); chk("scan rep", 32'h0000_00C6, v);
    wr(OFF_NMOD, 32'h0000_0002);
    wait_idle(); look();
    chk("scan rep irqs", 3, n_nirq);
    chk_chans(32'h0001_0101, 6);
    rd(OFF_RES0, v); chk("res0 overrun", 32'hC000_02A0, v);
    final_report();
  end
endmodule
